/* logic/mdi_dram_if.sv */
// one dram channel: command intake, bank/row tracking, word array, ddr data lanes
// assumes every pin input is asynchronous to CLK; the link clock is sampled, not used as a clock
`timescale 1ns/10ps
module mdi_dram_if #(
    parameter int NUM_BANKS = mdi_pkg::NUM_BANKS,
    parameter int DQ_W = mdi_pkg::DQ_W,
    parameter int BEATS = mdi_pkg::BEATS,
    parameter int BURST_WORDS = mdi_pkg::BURST_WORDS,
    parameter int FIFO_DEPTH = mdi_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // link clock and command
    input wire logic CLOCK_TRUE,
    input wire logic CLOCK_COMPLEMENT,
    input wire logic CKE,
    input wire logic CS,
    input wire logic [mdi_pkg::CA_W-1:0] CMD_ADDR_BUS,
    // mode: 0 inversion, 1 write mask
    input wire logic MASK_MODE,
    // data lanes
    input wire logic [DQ_W-1:0] DQ_I,
    output logic [DQ_W-1:0] DQ_O,
    output logic DQ_OE,
    // strobe pair
    input wire logic DQS_T_I,
    output logic DQS_T_O,
    output logic DQS_C_O,
    output logic DQS_OE,
    // mask/invert lane
    input wire logic MASK_INVERT_LANE_I,
    output logic MASK_INVERT_LANE_O,
    output logic MASK_INVERT_LANE_OE
);
    import mdi_pkg::*;

    localparam int NWORDS = NUM_BANKS * (2 ** ROW_IDX_W) * (2 ** COL_W);
    localparam int IDX_W = BANK_W + ROW_IDX_W + COL_W;
    localparam int SW = 6 + CA_W + DQ_W;
    localparam int WW = BEATS * DQ_W;
    localparam int BW = $clog2(BEATS);

    typedef logic [BEATS-1:0][DQ_W-1:0] mdi_word_t;

    function automatic logic [IDX_W-1:0] mem_idx(input logic [BANK_W-1:0] b,
        input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
        mem_idx = {b, r[ROW_IDX_W-1:0], c};
    endfunction

    function automatic logic more_ones(input logic [DQ_W-1:0] d);
        int n;
        n = 0;
        for (int i = 0; i < DQ_W; i++) n += int'(d[i]);
        more_ones = (n > DQ_W / 2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge finding

    logic [SW-1:0] sync_m_q;
    logic [SW-1:0] sync_q;
    logic clk_t_p_q;
    logic dqs_m_q;
    logic dqs_s_q;
    logic dqs_p_q;

    wire [SW-1:0] raw = {CLOCK_TRUE, CLOCK_COMPLEMENT, CKE, CS, MASK_MODE,
        MASK_INVERT_LANE_I, CMD_ADDR_BUS, DQ_I};

    always_ff @(posedge CLK) begin
        sync_m_q <= raw;
        sync_q <= sync_m_q;
        clk_t_p_q <= sync_q[SW-1];
        dqs_p_q <= dqs_s_q;
    end

    always_ff @(posedge CLK) begin
        dqs_m_q <= DQS_T_I;
        dqs_s_q <= dqs_m_q;
    end

    wire clk_t_s = sync_q[SW-1];
    wire clk_c_s = sync_q[SW-2];
    wire cke_s = sync_q[SW-3];
    wire cs_s = sync_q[SW-4];
    wire mode_s = sync_q[SW-5];
    wire mi_s = sync_q[SW-6];
    wire [CA_W-1:0] ca_s = sync_q[DQ_W +: CA_W];
    wire [DQ_W-1:0] dq_s = sync_q[DQ_W-1:0];

    // true rising while complement low
    wire link_rise = clk_t_s && !clk_t_p_q && !clk_c_s;
    wire link_fall = !clk_t_s && clk_t_p_q;
    wire link_edge = link_rise || link_fall;
    wire dqs_edge = dqs_s_q ^ dqs_p_q;

    ////////////////////////////////////////////////////////////////////////////////
    // two-half command intake

    mdi_cmd_st_t cmd_st_q;
    logic [OP_W-1:0] op_q;
    logic [BANK_W-1:0] bank_q;
    logic [ROW_W-1:0] row_q [NUM_BANKS];
    logic [NUM_BANKS-1:0] open_q;

    // a low clock enable freezes intake mid-command
    wire take = link_rise && cke_s;
    wire exec = take && (cmd_st_q == MDI_CMD_SECOND);
    wire do_act = exec && (op_q == OP_ACT);
    wire acc_ok = exec && open_q[bank_q];
    wire do_rd = acc_ok && (op_q == OP_RD);
    wire do_wr = acc_ok && ((op_q == OP_WR) || (op_q == OP_MWR));

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cmd_st_q <= MDI_CMD_FIRST;
            op_q <= '0;
            bank_q <= '0;
            open_q <= '0;
        end else if (take) begin
            unique case (cmd_st_q)
                MDI_CMD_FIRST: begin
                    if (cs_s) begin
                        op_q <= ca_s[OP_LSB +: OP_W];
                        bank_q <= ca_s[BANK_LSB +: BANK_W];
                        cmd_st_q <= MDI_CMD_SECOND;
                    end
                end
                MDI_CMD_SECOND: begin
                    if (do_act) open_q[bank_q] <= 1'b1;
                    cmd_st_q <= MDI_CMD_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (do_act) row_q[bank_q] <= ca_s[ROW_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write path: beats taken on host strobe edges, committed a word at a time

    mdi_word_t mem_q [NWORDS];
    logic [CNT_W-1:0] wr_left_q;
    logic [BW-1:0] wr_beat_q;
    logic [COL_W-1:0] wr_col_q;
    logic [BANK_W-1:0] wr_bank_q;
    logic wr_mask_q;
    mdi_word_t wr_buf_q;
    logic [BEATS-1:0] wr_en_q;
    logic wr_commit_q;
    logic [IDX_W-1:0] wr_idx_q;

    wire wr_take = dqs_edge && (wr_left_q != '0);
    wire wr_last = wr_take && (wr_beat_q == BW'(BEATS - 1));
    // inversion mode restores the true data; mask mode passes it as is
    wire [DQ_W-1:0] wr_beat = (!mode_s && mi_s) ? ~dq_s : dq_s;
    wire wr_keep = !(mode_s && wr_mask_q && mi_s);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_left_q <= '0;
            wr_beat_q <= '0;
            wr_commit_q <= 1'b0;
        end else begin
            wr_commit_q <= wr_last;
            if (do_wr) begin
                wr_left_q <= CNT_W'(BURST_WORDS);
                wr_beat_q <= '0;
            end else if (wr_take) begin
                wr_beat_q <= wr_beat_q + 1'b1;
                if (wr_last) wr_left_q <= wr_left_q - 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (do_wr) begin
            wr_bank_q <= bank_q;
            wr_col_q <= ca_s[COL_W-1:0];
            wr_mask_q <= (op_q == OP_MWR);
        end else if (wr_last) begin
            wr_col_q <= wr_col_q + 1'b1;
        end
        if (wr_take) begin
            wr_buf_q[wr_beat_q] <= wr_beat;
            wr_en_q[wr_beat_q] <= wr_keep;
        end
        if (wr_last) wr_idx_q <= mem_idx(wr_bank_q, row_q[wr_bank_q], wr_col_q);
    end

    always_ff @(posedge CLK) begin
        for (int b = 0; b < BEATS; b++) begin
            if (wr_commit_q && wr_en_q[b]) mem_q[wr_idx_q][b] <= wr_buf_q[b];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path: words fetched into the fifo, drained one beat per link edge

    logic [CNT_W-1:0] rd_left_q;
    logic [COL_W-1:0] rd_col_q;
    logic [BANK_W-1:0] rd_bank_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WW-1:0] fifo_out_data;

    // the fetch stalls on a full fifo, so the drain pace sets the fill pace
    wire rd_push = (rd_left_q != '0) && fifo_in_ready;
    wire [WW-1:0] rd_word = mem_q[mem_idx(rd_bank_q, row_q[rd_bank_q], rd_col_q)];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rd_left_q <= '0;
        end else if (do_rd) begin
            rd_left_q <= CNT_W'(BURST_WORDS);
        end else if (rd_push) begin
            rd_left_q <= rd_left_q - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (do_rd) begin
            rd_bank_q <= bank_q;
            rd_col_q <= ca_s[COL_W-1:0];
        end else if (rd_push) begin
            rd_col_q <= rd_col_q + 1'b1;
        end
    end

    logic [BW:0] ser_left_q;
    logic [BW-1:0] ser_idx_q;
    mdi_word_t ser_word_q;

    wire ser_pop = link_edge && cke_s && (ser_left_q == '0) && fifo_out_valid;
    wire ser_more = link_edge && cke_s && (ser_left_q != '0);
    wire mdi_word_t pop_word = fifo_out_data;
    wire [DQ_W-1:0] beat = ser_pop ? pop_word[0] : ser_word_q[ser_idx_q];
    wire beat_inv = !mode_s && more_ones(beat);

    mdi_fifo #(
        .W(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .CLK(CLK),
        .RST_N(RST_N),
        .in_valid(rd_push),
        .in_ready(fifo_in_ready),
        .in_data(rd_word),
        .out_valid(fifo_out_valid),
        .out_ready(ser_pop),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ser_left_q <= '0;
            ser_idx_q <= '0;
            DQ_O <= '0;
            DQ_OE <= 1'b0;
            DQS_T_O <= 1'b0;
            DQS_C_O <= 1'b1;
            DQS_OE <= 1'b0;
            MASK_INVERT_LANE_O <= 1'b0;
            MASK_INVERT_LANE_OE <= 1'b0;
        end else if (!cke_s) begin
            DQ_OE <= 1'b0;
            DQS_OE <= 1'b0;
            MASK_INVERT_LANE_OE <= 1'b0;
        end else if (ser_pop || ser_more) begin
            if (ser_pop) begin
                ser_word_q <= pop_word;
                ser_left_q <= (BW+1)'(BEATS - 1);
                ser_idx_q <= BW'(1);
            end else begin
                ser_left_q <= ser_left_q - 1'b1;
                ser_idx_q <= ser_idx_q + 1'b1;
            end
            DQ_O <= beat_inv ? ~beat : beat;
            MASK_INVERT_LANE_O <= beat_inv;
            DQS_T_O <= link_rise;
            DQS_C_O <= !link_rise;
            DQ_OE <= 1'b1;
            DQS_OE <= 1'b1;
            MASK_INVERT_LANE_OE <= 1'b1;
        end else if (link_edge) begin
            DQ_OE <= 1'b0;
            DQS_OE <= 1'b0;
            MASK_INVERT_LANE_OE <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    half_order_a: assert property (@(posedge CLK) disable iff (!RST_N)
        exec |-> $past(cmd_st_q) == MDI_CMD_SECOND ##1 cmd_st_q == MDI_CMD_FIRST)
        else $error("second half did not close the command");
    rise_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (cmd_st_q != $past(cmd_st_q)) |-> $past(link_rise && cke_s))
        else $error("command state moved off a rising link edge");
    strobe_phase_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (ser_pop || ser_more) |=> DQS_T_O == $past(link_rise) && DQS_C_O != DQS_T_O)
        else $error("strobe not aligned with beat edge");
    word_beats_a: assert property (@(posedge CLK) disable iff (!RST_N)
        ser_pop |=> ser_left_q == (BW+1)'(BEATS - 1))
        else $error("word did not load a full set of beats");
    act_row_a: assert property (@(posedge CLK) disable iff (!RST_N)
        do_act |=> open_q[$past(bank_q)] && row_q[$past(bank_q)] == $past(ca_s[ROW_W-1:0]))
        else $error("activate did not open the row");
    burst_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        do_rd |=> rd_left_q == CNT_W'(BURST_WORDS) && rd_col_q == $past(ca_s[COL_W-1:0]))
        else $error("read burst start wrong");
    cke_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !cke_s |=> !DQ_OE && !DQS_OE && !MASK_INVERT_LANE_OE)
        else $error("lanes driven with clock enable low");
    invert_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (DQ_OE && !$past(mode_s)) |-> !more_ones(DQ_O) && (DQS_OE == DQ_OE))
        else $error("driven byte has too many ones");

endmodule // mdi_dram_if

/* logic/mdi_pkg.sv */
// constants, opcodes and command state type for the command/data interface of a low-power dram channel
// assumes one package compiled before every design file that imports it
package mdi_pkg;

    localparam int CA_W = 6;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int DQ_W = 8;
    localparam int BEATS = 8;
    localparam int BURST_WORDS = 2;
    localparam int COL_W = 3;
    localparam int ROW_W = 6;
    localparam int ROW_IDX_W = 1;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = 4;

    // first command half: opcode in the low bits, bank above it
    localparam int OP_LSB = 0;
    localparam int OP_W = 3;
    localparam int BANK_LSB = 3;

    localparam logic [OP_W-1:0] OP_ACT = 3'h1;
    localparam logic [OP_W-1:0] OP_RD = 3'h2;
    localparam logic [OP_W-1:0] OP_WR = 3'h3;
    localparam logic [OP_W-1:0] OP_MWR = 3'h4;

    localparam int CLK_PERIOD_PS = 4000;

    typedef enum logic {MDI_CMD_FIRST, MDI_CMD_SECOND} mdi_cmd_st_t;

endpackage

/* logic/mdi_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset shared with its user
`timescale 1ns/10ps
module mdi_fifo #(
    parameter int W = 64,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] used = wr_ptr_q - rd_ptr_q;

    assign in_ready = (used != (AW+1)'(DEPTH));
    assign out_valid = (used != '0);
    assign out_data = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge CLK) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + (AW+1)'(1) : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + (AW+1)'(1) : rd_ptr_q;
        end
    end

    fifo_bound_a: assert property (@(posedge CLK) disable iff (!RST_N)
        used <= (AW+1)'(DEPTH))
        else $error("fifo holds more words than its depth");

endmodule // mdi_fifo

/* dv/mdi_host_model.sv */
// host controller model: link clock, command halves, write strobe and data, read capture
// assumes the bench calls its tasks and empties its capture queues
`timescale 1ns/10ps
module mdi_host_model (
    // clock
    input wire logic clk,
    // host drive
    output logic ck_t,
    output logic ck_c,
    output logic cke,
    output logic cs,
    output logic [5:0] ca,
    output logic [7:0] dq,
    output logic dqs,
    output logic mil,
    // device drive
    input wire logic [7:0] dq_o,
    input wire logic dq_oe,
    input wire logic dqs_t_o,
    input wire logic dqs_c_o,
    input wire logic mil_o
);
    logic [7:0] rd_d[$];
    logic rd_f[$];
    logic rd_s[$];
    logic oe_q = 1'b0;
    logic st_q = 1'b0;

    initial begin
        ck_t = 1'b0;
        ck_c = 1'b1;
        cke = 1'b1;
        cs = 1'b0;
        ca = 6'h00;
        dq = 8'h00;
        dqs = 1'b0;
        mil = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // clock stands low between frames; inputs held 3 clk before the rise and 9 clk after it
    task automatic link_cycle();
        wait_clk(3);
        ck_t = 1'b1;
        ck_c = 1'b0;
        wait_clk(6);
        ck_t = 1'b0;
        ck_c = 1'b1;
        wait_clk(3);
    endtask

    task automatic send_cmd(input logic c, input logic [5:0] h1, input logic [5:0] h2);
        cs = c;
        ca = h1;
        link_cycle();
        cs = 1'b0;
        ca = h2;
        link_cycle();
        ca = ~h2;
    endtask

    task automatic write_beats(input logic [7:0] b[16], input logic [15:0] fl);
        for (int i = 0; i < 16; i++) begin
            dq = b[i];
            mil = fl[i];
            wait_clk(2);
            dqs = ~dqs;
            wait_clk(4);
        end
        // released lanes must not keep showing the last beat
        dq = ~dq;
        mil = ~mil;
        wait_clk(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one beat on the first driven cycle, then one per change of the read strobe while the lanes are driven
    always @(posedge clk) begin
        oe_q <= dq_oe;
        st_q <= dqs_t_o;
        if (dq_oe === 1'b1 && (!oe_q || dqs_t_o != st_q)) begin
            rd_d.push_back(dq_o);
            rd_f.push_back(mil_o);
            rd_s.push_back(dqs_t_o ^ dqs_c_o);
        end
    end
endmodule // mdi_host_model

/* dv/mobile_dram_cmd_data_if_bench.sv */
// bench for one dram channel: writes, masked writes, row selection, refused commands
// assumes the host model in dv and the design package compiled first
`timescale 1ns/10ps
module mobile_dram_cmd_data_if_bench;
    import mdi_pkg::*;
    logic clk, rst_n, mask_mode, ck_t, ck_c, cke, cs, dqs, mil;
    logic dq_oe, dqs_t_o, dqs_c_o, dqs_oe, mil_o, mil_oe;
    logic [5:0] ca;
    logic [7:0] dq, dq_o;
    logic [7:0] wr[16];
    logic [7:0] exp_b[16];
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    mdi_dram_if uut (.CLK(clk), .RST_N(rst_n), .CLOCK_TRUE(ck_t), .CLOCK_COMPLEMENT(ck_c),
        .CKE(cke), .CS(cs), .CMD_ADDR_BUS(ca), .MASK_MODE(mask_mode), .DQ_I(dq),
        .DQ_O(dq_o), .DQ_OE(dq_oe), .DQS_T_I(dqs), .DQS_T_O(dqs_t_o), .DQS_C_O(dqs_c_o),
        .DQS_OE(dqs_oe), .MASK_INVERT_LANE_I(mil), .MASK_INVERT_LANE_O(mil_o),
        .MASK_INVERT_LANE_OE(mil_oe));

    mdi_host_model host (.clk(clk), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs(cs), .ca(ca),
        .dq(dq), .dqs(dqs), .mil(mil), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o),
        .dqs_c_o(dqs_c_o), .mil_o(mil_o));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string msg);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: %s seen %h want %h", $time, msg, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ceiling well above the roughly 1640 cycles the scenarios need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            $display("mismatch at %0t: cycle limit reached", $time);
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // after traffic the lanes keep the last beat; only reset clears them
    task automatic t_idle(input logic fresh);
        logic flg;
        flg = ($countones(exp_b[15]) > 4);
        check({5'h0, dq_oe, dqs_oe, mil_oe}, 8'h00, "idle enables");
        if (fresh) begin
            check(dq_o, 8'h00, "idle data");
            check({6'h0, dqs_t_o, dqs_c_o}, 8'h01, "idle strobe");
        end else begin
            check(dq_o ^ {8{mil_o}}, exp_b[15], "held data");
            check({7'h0, mil_o}, {7'h0, flg}, "held flag");
            check({7'h0, dqs_t_o ^ dqs_c_o}, 8'h01, "held strobe pair");
        end
    endtask

    task automatic do_write(input logic [2:0] op, input logic [15:0] fl);
        logic [7:0] s[16];
        for (int i = 0; i < 16; i++) begin
            s[i] = (fl[i] && !mask_mode) ? ~wr[i] : wr[i];
        end
        host.send_cmd(1'b1, {3'h2, op}, 6'h07);
        host.write_beats(s, fl);
    endtask

    // column 7 on purpose: the second word wraps to column 0
    task automatic read_burst(input logic [2:0] bk);
        host.rd_d.delete();
        host.rd_f.delete();
        host.rd_s.delete();
        host.send_cmd(1'b1, {bk, OP_RD}, 6'h07);
        repeat (14) host.link_cycle();
    endtask

    task automatic verify(input logic [7:0] e[16], input logic inv);
        logic flg;
        check(8'(host.rd_d.size()), 8'h10, "beat count");
        for (int i = 0; i < 16 && i < host.rd_d.size(); i++) begin
            flg = inv && ($countones(e[i]) > 4);
            check(host.rd_d[i] ^ {8{host.rd_f[i]}}, e[i], "read beat");
            check({7'h0, host.rd_f[i]}, {7'h0, flg}, "invert flag");
            check({7'h0, host.rd_s[i]}, 8'h01, "strobe pair");
        end
    endtask

    task automatic t_write_read();
        for (int i = 0; i < 16; i++) begin
            wr[i] = 8'(i * 37);
        end
        wr[0] = 8'hff;
        host.send_cmd(1'b1, {3'h2, OP_ACT}, 6'h01);
        do_write(OP_WR, 16'haaaa);
        read_burst(3'h2);
        verify(wr, 1'b1);
    endtask

    task automatic t_mask();
        mask_mode = 1'b1;
        exp_b = wr;
        for (int i = 0; i < 16; i++) begin
            wr[i] = wr[i] ^ 8'h5a;
            if (i != 3) begin
                exp_b[i] = wr[i];
            end
        end
        do_write(OP_MWR, 16'h0008);
        read_burst(3'h2);
        verify(exp_b, 1'b0);
        mask_mode = 1'b0;
    endtask

    task automatic t_row();
        for (int i = 0; i < 16; i++) begin
            wr[i] = ~exp_b[i];
        end
        host.send_cmd(1'b1, {3'h2, OP_ACT}, 6'h00);
        do_write(OP_WR, 16'h0000);
        host.send_cmd(1'b1, {3'h2, OP_ACT}, 6'h01);
        read_burst(3'h2);
        verify(exp_b, 1'b1);
    endtask

    task automatic t_refused();
        read_burst(3'h5);
        check(8'(host.rd_d.size()), 8'h00, "unopened bank");
        host.send_cmd(1'b0, {3'h6, OP_ACT}, 6'h01);
        read_burst(3'h6);
        check(8'(host.rd_d.size()), 8'h00, "deselected activate");
        host.cke = 1'b0;
        read_burst(3'h2);
        check(8'(host.rd_d.size()), 8'h00, "clock enable low");
        host.cke = 1'b1;
        t_idle(1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        mask_mode = 1'b0;
        repeat (12) @(negedge clk);
        t_idle(1'b1);
        rst_n = 1'b1;
        @(negedge clk);
        t_idle(1'b1);
        t_write_read();
        t_mask();
        t_row();
        t_refused();
        end_of_test();
    end
endmodule // mobile_dram_cmd_data_if_bench
